// >>> inc/ppbc_consts.svh
// Offsets, field positions and reset values of the coding and self-test register bank.
`ifndef PPBC_CONSTS_SVH
`define PPBC_CONSTS_SVH

// Management address and data widths.
`define PPBC_ADDR_W 5
`define PPBC_DATA_W 16

// Register offsets on the management port.
`define PPBC_OFS_PCS 5'h16
`define PPBC_OFS_RSV_A 5'h17
`define PPBC_OFS_RSV_B 5'h18
`define PPBC_OFS_MISC 5'h19

// Coding configuration register field positions.
`define PPBC_PCS_BLOCK_SKIP 12
`define PPBC_PCS_FREE_CLK 11
`define PPBC_PCS_TRUE_QUIET 10
`define PPBC_PCS_SD_FORCE 9
`define PPBC_PCS_SD_ALGO 8
`define PPBC_PCS_FORCE_LINK 5
`define PPBC_PCS_NRZI_SKIP 2
`define PPBC_PCS_SCRAM_SKIP 1
`define PPBC_PCS_DESCRAM_SKIP 0

// Miscellaneous control register field positions.
`define PPBC_MISC_LONG_SEQ 11
`define PPBC_MISC_RESULT 10
`define PPBC_MISC_RUN 9
`define PPBC_MISC_STRETCH_SKIP 8
`define PPBC_MISC_PAUSE 7
`define PPBC_MISC_FIXED_ONE 6
`define PPBC_MISC_LED_POL 5
`define PPBC_MISC_ADDR_MSB 4
`define PPBC_MISC_ADDR_LSB 0

// Reset values.
`define PPBC_SD_ALGO_RESET 1'b1
`define PPBC_RSV_RESET 16'h0000
`define PPBC_RESULT_RESET 1'b0
`define PPBC_ADDR_RESET 5'h00

`endif

// >>> inc/ppbc_pkg.sv
// Types shared by the coding and self-test register bank.
package ppbc_pkg;

  // Register selected by the management address.
  typedef enum logic [2:0] {
    PPBC_SEL_NONE = 3'b000,
    PPBC_SEL_PCS = 3'b001,
    PPBC_SEL_RSV_A = 3'b010,
    PPBC_SEL_RSV_B = 3'b011,
    PPBC_SEL_MISC = 3'b100
  } ppbc_reg_sel_t;

  // Writable controls of the coding configuration register.
  typedef struct packed {
    logic block_code_skip;
    logic rx_clk_free_run;
    logic true_quiet_tx_enable;
    logic signal_detect_force;
    logic signal_detect_algo_select;
    logic force_good_link_100;
    logic nrzi_skip;
    logic scrambler_skip;
    logic descrambler_skip;
  } ppbc_pcs_cfg_t;

  // Writable controls of the miscellaneous control register.
  typedef struct packed {
    logic selftest_long_sequence_select;
    logic self_test_run;
    logic led_pulse_stretch_skip;
    logic duplex_led_polarity_cfg;
    logic [4:0] port_address;
  } ppbc_misc_cfg_t;

endpackage

// >>> core/ppbc_strap_latch.sv
// Capture of the strap levels while reset is held, with a load pulse at release.
`timescale 1ns/1ps
`include "ppbc_consts.svh"

module ppbc_strap_latch (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Strap levels.
  input wire logic [4:0] strap_addr,
  input wire logic strap_led_pol,
  // Captured values and the one-cycle load pulse.
  output logic [4:0] cap_addr,
  output logic cap_led_pol,
  output logic load
);

  logic rst_q;
  logic [4:0] addr_q;
  logic pol_q;

  // The straps are sampled on every clocked edge of reset, so the last level before release wins.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      addr_q <= strap_addr;
      pol_q <= strap_led_pol;
    end
  end

  // Delayed reset marks the first edge after release.
  always_ff @(posedge clk)
  begin
    rst_q <= rst;
  end

  assign load = rst_q & ~rst;
  assign cap_addr = addr_q;
  assign cap_led_pol = pol_q;

endmodule

// >>> core/ppbc_selftest_result.sv
// Latched pass or fail result of the built-in packet self-test.
`timescale 1ns/1ps
`include "ppbc_consts.svh"

module ppbc_selftest_result (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Test state and events.
  input wire logic running,
  input wire logic fail,
  input wire logic rearm,
  // Latched result, one for pass.
  output logic result
);

  logic result_q;

  // A failure seen in the same cycle as the re-arm write still latches low, so no fault is lost.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      result_q <= `PPBC_RESULT_RESET;
    end
    else if (fail && running)
    begin
      result_q <= 1'b0;
    end
    else if (rearm)
    begin
      result_q <= 1'b1;
    end
  end

  assign result = result_q;

endmodule

// >>> core/ppbc_config_regs.sv
// Coding-path configuration, reserved and self-test control registers of the transceiver.
`timescale 1ns/1ps
`include "ppbc_consts.svh"

// Functional notes
// - Coding bit 12 set bypasses the 4-bit to 5-bit block encoder; resets to zero.
// - Coding bit 11 set lets receive clock run free; clear aligns its phase.
// - Coding bit 10 set puts the 100 Mb/s transmitter in true quiet mode.
// - Coding bit 9 set forces signal detect asserted regardless of the line.
// - Coding bit 8, reset one, picks enhanced signal detect; clear picks reduced.
// - Coding bit 5 set forces a good 100 Mb/s link.
// - Coding bit 2 set bypasses the line coding stage; resets to zero.
// - Coding bit 1 set bypasses the transmit scrambler; resets to zero.
// - Coding bit 0 set bypasses the receive descrambler; resets to zero.
// - Coding bits 15 to 13 ignore writes and read zero.
// - Misc bit 9 runs self-test, bit 11 picks sequence, bit 10 latches result.
// - Misc bit 8 set skips pulse stretching on activity and collision indicators.
// - Misc bit 7 reads one only when both ends advertise pause.
// - Misc bit 5, strapped at reset, picks LED or plain duplex indicator polarity.
// - Misc bits 4 to 0 hold the strapped port address, writable later.
module ppbc_config_regs (
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic RST,
  // Management register port.
  input wire logic [4:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [15:0] RDATA,
  output logic RD_VALID,
  // Strap levels.
  input wire logic [4:0] STRAP_PORT_ADDRESS,
  input wire logic STRAP_DUPLEX_LED_POLARITY,
  // Status from the datapath.
  input wire logic LOCAL_PAUSE_CAPABLE,
  input wire logic PARTNER_PAUSE_CAPABLE,
  input wire logic SIGNAL_DETECT_LINE,
  input wire logic LINK_GOOD_100_RAW,
  input wire logic DUPLEX_STATUS,
  input wire logic SELF_TEST_FAIL,
  // Coding-path controls.
  output logic BLOCK_CODE_SKIP,
  output logic RX_CLK_FREE_RUN,
  output logic TRUE_QUIET_TX_ENABLE,
  output logic SIGNAL_DETECT_FORCE,
  output logic SIGNAL_DETECT_ALGO_SELECT,
  output logic FORCE_GOOD_LINK_100,
  output logic NRZI_SKIP,
  output logic SCRAMBLER_SKIP,
  output logic DESCRAMBLER_SKIP,
  // Qualified datapath status.
  output logic SIGNAL_DETECT_PMA,
  output logic LINK_GOOD_100,
  // Self-test and indicator controls.
  output logic SELF_TEST_RUN,
  output logic SELFTEST_LONG_SEQUENCE_SELECT,
  output logic SELF_TEST_RESULT,
  output logic LED_PULSE_STRETCH_SKIP,
  output logic DUPLEX_INDICATOR,
  output logic [4:0] PORT_ADDRESS
);

  ppbc_pkg::ppbc_pcs_cfg_t pcs_q;
  ppbc_pkg::ppbc_misc_cfg_t misc_q;
  ppbc_pkg::ppbc_reg_sel_t sel;
  logic [15:0] rsv_a_q;
  logic [15:0] rsv_b_q;
  logic [15:0] rd_word;
  logic [15:0] rdata_q;
  logic rd_valid_q;
  logic wr_pcs;
  logic wr_rsv_a;
  logic wr_rsv_b;
  logic wr_misc;
  logic pause_q;
  logic sd_pma_q;
  logic link_100_q;
  logic duplex_ind_q;
  logic result;
  logic strap_load;
  logic [4:0] strap_addr;
  logic strap_led_pol;

  // Address decode; anything outside the four offsets selects nothing.
  always_comb
  begin
    unique case (ADDR)
      `PPBC_OFS_PCS: sel = ppbc_pkg::PPBC_SEL_PCS;
      `PPBC_OFS_RSV_A: sel = ppbc_pkg::PPBC_SEL_RSV_A;
      `PPBC_OFS_RSV_B: sel = ppbc_pkg::PPBC_SEL_RSV_B;
      `PPBC_OFS_MISC: sel = ppbc_pkg::PPBC_SEL_MISC;
      default: sel = ppbc_pkg::PPBC_SEL_NONE;
    endcase
  end

  // Write enables per register.
  assign wr_pcs = WR_STB && (sel == ppbc_pkg::PPBC_SEL_PCS);
  assign wr_rsv_a = WR_STB && (sel == ppbc_pkg::PPBC_SEL_RSV_A);
  assign wr_rsv_b = WR_STB && (sel == ppbc_pkg::PPBC_SEL_RSV_B);
  assign wr_misc = WR_STB && (sel == ppbc_pkg::PPBC_SEL_MISC);

  // Strap capture runs beside the register file so the port address is known at release.
  ppbc_strap_latch u_strap (
    .clk(CLK_SYS),
    .rst(RST),
    .strap_addr(STRAP_PORT_ADDRESS),
    .strap_led_pol(STRAP_DUPLEX_LED_POLARITY),
    .cap_addr(strap_addr),
    .cap_led_pol(strap_led_pol),
    .load(strap_load)
  );

  // Coding configuration controls; only the defined bits are stored.
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      pcs_q.block_code_skip <= 1'b0;
      pcs_q.rx_clk_free_run <= 1'b0;
      pcs_q.true_quiet_tx_enable <= 1'b0;
      pcs_q.signal_detect_force <= 1'b0;
      pcs_q.signal_detect_algo_select <= `PPBC_SD_ALGO_RESET;
      pcs_q.force_good_link_100 <= 1'b0;
      pcs_q.nrzi_skip <= 1'b0;
      pcs_q.scrambler_skip <= 1'b0;
      pcs_q.descrambler_skip <= 1'b0;
    end
    else if (wr_pcs)
    begin
      pcs_q.block_code_skip <= WDATA[`PPBC_PCS_BLOCK_SKIP];
      pcs_q.rx_clk_free_run <= WDATA[`PPBC_PCS_FREE_CLK];
      pcs_q.true_quiet_tx_enable <= WDATA[`PPBC_PCS_TRUE_QUIET];
      pcs_q.signal_detect_force <= WDATA[`PPBC_PCS_SD_FORCE];
      pcs_q.signal_detect_algo_select <= WDATA[`PPBC_PCS_SD_ALGO];
      pcs_q.force_good_link_100 <= WDATA[`PPBC_PCS_FORCE_LINK];
      pcs_q.nrzi_skip <= WDATA[`PPBC_PCS_NRZI_SKIP];
      pcs_q.scrambler_skip <= WDATA[`PPBC_PCS_SCRAM_SKIP];
      pcs_q.descrambler_skip <= WDATA[`PPBC_PCS_DESCRAM_SKIP];
    end
  end

  // Reserved full-width registers. They are plain storage with no effect on the datapath;
  // they are cleared at reset only so that simulation never reads unknowns.
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      rsv_a_q <= `PPBC_RSV_RESET;
      rsv_b_q <= `PPBC_RSV_RESET;
    end
    else
    begin
      if (wr_rsv_a)
      begin
        rsv_a_q <= WDATA;
      end
      if (wr_rsv_b)
      begin
        rsv_b_q <= WDATA;
      end
    end
  end

  // Self-test run and sequence select.
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      misc_q.selftest_long_sequence_select <= 1'b0;
      misc_q.self_test_run <= 1'b0;
    end
    else if (wr_misc)
    begin
      misc_q.selftest_long_sequence_select <= WDATA[`PPBC_MISC_LONG_SEQ];
      misc_q.self_test_run <= WDATA[`PPBC_MISC_RUN];
    end
  end

  // Indicator stretch bypass.
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      misc_q.led_pulse_stretch_skip <= 1'b0;
    end
    else if (wr_misc)
    begin
      misc_q.led_pulse_stretch_skip <= WDATA[`PPBC_MISC_STRETCH_SKIP];
    end
  end

  // Strapped fields: zero while reset is held, strap value at the first edge after release,
  // software value afterwards. A write in the release cycle wins over the strap.
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      misc_q.duplex_led_polarity_cfg <= 1'b0;
      misc_q.port_address <= `PPBC_ADDR_RESET;
    end
    else if (wr_misc)
    begin
      misc_q.duplex_led_polarity_cfg <= WDATA[`PPBC_MISC_LED_POL];
      misc_q.port_address <= WDATA[`PPBC_MISC_ADDR_MSB:`PPBC_MISC_ADDR_LSB];
    end
    else if (strap_load)
    begin
      misc_q.duplex_led_polarity_cfg <= strap_led_pol;
      misc_q.port_address <= strap_addr;
    end
  end

  // A write to the miscellaneous register re-arms the latched result unless a failure while running arrives in the same cycle.
  ppbc_selftest_result u_result (
    .clk(CLK_SYS),
    .rst(RST),
    .running(misc_q.self_test_run),
    .fail(SELF_TEST_FAIL),
    .rearm(wr_misc),
    .result(result)
  );

  // Pause compare is registered so the readback and the source stay one cycle apart.
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      pause_q <= 1'b0;
    end
    else
    begin
      pause_q <= LOCAL_PAUSE_CAPABLE & PARTNER_PAUSE_CAPABLE;
    end
  end

  // Qualified signal detect and link status toward the 100 Mb/s path.
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      sd_pma_q <= 1'b0;
      link_100_q <= 1'b0;
    end
    else
    begin
      sd_pma_q <= SIGNAL_DETECT_LINE | pcs_q.signal_detect_force;
      link_100_q <= LINK_GOOD_100_RAW | pcs_q.force_good_link_100;
    end
  end

  // Duplex indicator: LED mode drives it active low to sink an LED, plain mode active high.
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      duplex_ind_q <= 1'b0;
    end
    else
    begin
      duplex_ind_q <= misc_q.duplex_led_polarity_cfg ? ~DUPLEX_STATUS : DUPLEX_STATUS;
    end
  end

  // Read multiplexer; reserved and unused bits are built in as constants.
  always_comb
  begin
    rd_word = 16'h0000;
    unique case (sel)
      ppbc_pkg::PPBC_SEL_PCS:
      begin
        rd_word[`PPBC_PCS_BLOCK_SKIP] = pcs_q.block_code_skip;
        rd_word[`PPBC_PCS_FREE_CLK] = pcs_q.rx_clk_free_run;
        rd_word[`PPBC_PCS_TRUE_QUIET] = pcs_q.true_quiet_tx_enable;
        rd_word[`PPBC_PCS_SD_FORCE] = pcs_q.signal_detect_force;
        rd_word[`PPBC_PCS_SD_ALGO] = pcs_q.signal_detect_algo_select;
        rd_word[`PPBC_PCS_FORCE_LINK] = pcs_q.force_good_link_100;
        rd_word[`PPBC_PCS_NRZI_SKIP] = pcs_q.nrzi_skip;
        rd_word[`PPBC_PCS_SCRAM_SKIP] = pcs_q.scrambler_skip;
        rd_word[`PPBC_PCS_DESCRAM_SKIP] = pcs_q.descrambler_skip;
      end
      ppbc_pkg::PPBC_SEL_RSV_A:
      begin
        rd_word = rsv_a_q;
      end
      ppbc_pkg::PPBC_SEL_RSV_B:
      begin
        rd_word = rsv_b_q;
      end
      ppbc_pkg::PPBC_SEL_MISC:
      begin
        rd_word[`PPBC_MISC_LONG_SEQ] = misc_q.selftest_long_sequence_select;
        rd_word[`PPBC_MISC_RESULT] = result;
        rd_word[`PPBC_MISC_RUN] = misc_q.self_test_run;
        rd_word[`PPBC_MISC_STRETCH_SKIP] = misc_q.led_pulse_stretch_skip;
        rd_word[`PPBC_MISC_PAUSE] = pause_q;
        rd_word[`PPBC_MISC_FIXED_ONE] = 1'b1;
        rd_word[`PPBC_MISC_LED_POL] = misc_q.duplex_led_polarity_cfg;
        rd_word[`PPBC_MISC_ADDR_MSB:`PPBC_MISC_ADDR_LSB] = misc_q.port_address;
      end
      ppbc_pkg::PPBC_SEL_NONE:
      begin
        rd_word = 16'h0000;
      end
    endcase
  end
  // Bits 15:13 of the coding register and 15:12 of the misc register stay at zero above.

  // Read data stand only in the cycle after the strobe and are zero otherwise,
  // which keeps stale words off the port.
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      rdata_q <= 16'h0000;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rdata_q <= RD_STB ? rd_word : 16'h0000;
      rd_valid_q <= RD_STB;
    end
  end

  // Outputs come straight from the register flip-flops.
  assign RDATA = rdata_q;
  assign RD_VALID = rd_valid_q;
  assign BLOCK_CODE_SKIP = pcs_q.block_code_skip;
  assign RX_CLK_FREE_RUN = pcs_q.rx_clk_free_run;
  assign TRUE_QUIET_TX_ENABLE = pcs_q.true_quiet_tx_enable;
  assign SIGNAL_DETECT_FORCE = pcs_q.signal_detect_force;
  assign SIGNAL_DETECT_ALGO_SELECT = pcs_q.signal_detect_algo_select;
  assign FORCE_GOOD_LINK_100 = pcs_q.force_good_link_100;
  assign NRZI_SKIP = pcs_q.nrzi_skip;
  assign SCRAMBLER_SKIP = pcs_q.scrambler_skip;
  assign DESCRAMBLER_SKIP = pcs_q.descrambler_skip;
  assign SIGNAL_DETECT_PMA = sd_pma_q;
  assign LINK_GOOD_100 = link_100_q;
  assign SELF_TEST_RUN = misc_q.self_test_run;
  assign SELFTEST_LONG_SEQUENCE_SELECT = misc_q.selftest_long_sequence_select;
  assign SELF_TEST_RESULT = result;
  assign LED_PULSE_STRETCH_SKIP = misc_q.led_pulse_stretch_skip;
  assign DUPLEX_INDICATOR = duplex_ind_q;
  assign PORT_ADDRESS = misc_q.port_address;

endmodule

// >>> dv/ppbc_config_regs_monitor.sv
// Concurrent checks on the management port and control outputs of the register bank.
`timescale 1ns/1ps
`include "ppbc_consts.svh"

module ppbc_config_regs_monitor (
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic RST,
  // Management port.
  input wire logic [4:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  input wire logic [15:0] RDATA,
  input wire logic RD_VALID,
  // Status inputs.
  input wire logic LOCAL_PAUSE_CAPABLE,
  input wire logic PARTNER_PAUSE_CAPABLE,
  input wire logic SIGNAL_DETECT_LINE,
  input wire logic LINK_GOOD_100_RAW,
  input wire logic SELF_TEST_FAIL,
  // Controls and status outputs.
  input wire logic BLOCK_CODE_SKIP,
  input wire logic RX_CLK_FREE_RUN,
  input wire logic TRUE_QUIET_TX_ENABLE,
  input wire logic SIGNAL_DETECT_FORCE,
  input wire logic SIGNAL_DETECT_ALGO_SELECT,
  input wire logic FORCE_GOOD_LINK_100,
  input wire logic NRZI_SKIP,
  input wire logic SCRAMBLER_SKIP,
  input wire logic DESCRAMBLER_SKIP,
  input wire logic SIGNAL_DETECT_PMA,
  input wire logic LINK_GOOD_100,
  input wire logic SELF_TEST_RUN,
  input wire logic SELFTEST_LONG_SEQUENCE_SELECT,
  input wire logic SELF_TEST_RESULT,
  input wire logic LED_PULSE_STRETCH_SKIP,
  input wire logic [4:0] PORT_ADDRESS
);
  logic [15:0] pcs_v;
  logic [15:0] misc_v;
  logic wr_pcs;
  logic wr_misc;
  logic fail_ev;

  // Outputs are placed at their register bit positions so whole words can be compared.
  assign pcs_v = {3'b000, BLOCK_CODE_SKIP, RX_CLK_FREE_RUN, TRUE_QUIET_TX_ENABLE,
    SIGNAL_DETECT_FORCE, SIGNAL_DETECT_ALGO_SELECT, 2'b00, FORCE_GOOD_LINK_100, 2'b00,
    NRZI_SKIP, SCRAMBLER_SKIP, DESCRAMBLER_SKIP};
  assign misc_v = {4'h0, SELFTEST_LONG_SEQUENCE_SELECT, SELF_TEST_RESULT, SELF_TEST_RUN,
    LED_PULSE_STRETCH_SKIP, 3'b000, PORT_ADDRESS};
  assign wr_pcs = WR_STB && ADDR == `PPBC_OFS_PCS;
  assign wr_misc = WR_STB && ADDR == `PPBC_OFS_MISC;
  assign fail_ev = SELF_TEST_RUN && SELF_TEST_FAIL;

  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  AST_RD_IDLE: assert property (!RD_STB |=> !RD_VALID && RDATA == 16'h0000)
    else $error("read data outside the answer cycle");
  AST_RD_ANSWER: assert property (RD_STB |=> RD_VALID)
    else $error("read answer missing");
  AST_PCS_WRITE: assert property (wr_pcs |=>
    pcs_v == ($past(WDATA) & 16'h1F27))
    else $error("coding controls differ from written word");
  AST_PCS_HOLD: assert property (!wr_pcs |=> $stable(pcs_v))
    else $error("coding controls changed without a write");
  AST_PCS_READ: assert property (RD_STB && ADDR == `PPBC_OFS_PCS |=> RDATA == $past(pcs_v))
    else $error("coding readback wrong");
  AST_SD_FORCE: assert property (!$past(RST) |->
    SIGNAL_DETECT_PMA == $past(SIGNAL_DETECT_LINE | SIGNAL_DETECT_FORCE))
    else $error("signal detect not qualified");
  AST_LINK_FORCE: assert property (!$past(RST) |->
    LINK_GOOD_100 == $past(LINK_GOOD_100_RAW | FORCE_GOOD_LINK_100))
    else $error("good link not qualified");
  AST_PAUSE: assert property (RD_STB && ADDR == `PPBC_OFS_MISC && !$past(RST) &&
    $stable(LOCAL_PAUSE_CAPABLE) && $stable(PARTNER_PAUSE_CAPABLE)
    |=> RDATA[7] == $past(LOCAL_PAUSE_CAPABLE & PARTNER_PAUSE_CAPABLE))
    else $error("pause status wrong");
  AST_MISC_READ: assert property (RD_STB && ADDR == `PPBC_OFS_MISC
    |=> (RDATA & 16'hFF5F) == ($past(misc_v) | 16'h0040))
    else $error("misc readback wrong");
  AST_MISC_WRITE: assert property (wr_misc |=>
    (misc_v & 16'h0B1F) == ($past(WDATA) & 16'h0B1F))
    else $error("misc controls differ from written word");
  AST_FAIL_LATCH: assert property (fail_ev |=> !SELF_TEST_RESULT)
    else $error("self-test failure not latched");
  AST_REARM: assert property (wr_misc && !fail_ev |=> SELF_TEST_RESULT)
    else $error("self-test result not rearmed");
  AST_RESULT_HOLD: assert property (!wr_misc && !fail_ev |=> $stable(SELF_TEST_RESULT))
    else $error("self-test result changed without cause");
endmodule

bind ppbc_config_regs ppbc_config_regs_monitor ppbc_config_regs_monitor_i (.*);

// >>> dv/tb.sv
// Self-checking bench for the coding and self-test register bank.
`timescale 1ns/1ps
`include "ppbc_consts.svh"

module tb;
  logic CLK_SYS, RST, WR_STB, RD_STB, RD_VALID, STRAP_DUPLEX_LED_POLARITY, SELF_TEST_FAIL;
  logic LOCAL_PAUSE_CAPABLE, PARTNER_PAUSE_CAPABLE, SIGNAL_DETECT_LINE, LINK_GOOD_100_RAW;
  logic DUPLEX_STATUS, BLOCK_CODE_SKIP, RX_CLK_FREE_RUN, TRUE_QUIET_TX_ENABLE;
  logic SIGNAL_DETECT_FORCE, SIGNAL_DETECT_ALGO_SELECT, FORCE_GOOD_LINK_100, NRZI_SKIP;
  logic SCRAMBLER_SKIP, DESCRAMBLER_SKIP, SIGNAL_DETECT_PMA, LINK_GOOD_100, SELF_TEST_RUN;
  logic SELFTEST_LONG_SEQUENCE_SELECT, SELF_TEST_RESULT, LED_PULSE_STRETCH_SKIP;
  logic DUPLEX_INDICATOR;
  logic [4:0] ADDR, STRAP_PORT_ADDRESS, PORT_ADDRESS, a;
  logic [15:0] WDATA, RDATA, d, pcs_m, rsv_a_m, rsv_b_m, misc_m;
  logic [31:0] r;
  logic res_m;
  int err_total = 0;
  int check_count = 0;
  integer seed = 32'h4699;

  ppbc_config_regs ppbc_config_regs_i (.*);

  // Free-running system clock.
  initial
  begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end

  task automatic summarize();
    if (err_total == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      err_total++;
    end
  endtask

  // Expected readback of any address, built from the bench's own copy of the registers.
  function automatic logic [15:0] exp_rd(input logic [4:0] ad);
    case (ad)
      `PPBC_OFS_PCS: return pcs_m;
      `PPBC_OFS_RSV_A: return rsv_a_m;
      `PPBC_OFS_RSV_B: return rsv_b_m;
      `PPBC_OFS_MISC: return misc_m | 16'h0040 |
        {5'h00, res_m, 2'b00, LOCAL_PAUSE_CAPABLE & PARTNER_PAUSE_CAPABLE, 7'h00};
      default: return 16'h0000;
    endcase
  endfunction

  task automatic wr(input logic [4:0] ad, input logic [15:0] dat);
    @(posedge CLK_SYS);
    ADDR <= ad;
    WDATA <= dat;
    WR_STB <= 1'b1;
    @(posedge CLK_SYS);
    WR_STB <= 1'b0;
    case (ad)
      `PPBC_OFS_PCS: pcs_m = dat & 16'h1F27;
      `PPBC_OFS_RSV_A: rsv_a_m = dat;
      `PPBC_OFS_RSV_B: rsv_b_m = dat;
      `PPBC_OFS_MISC:
      begin
        misc_m = dat & 16'h0B3F;
        res_m = 1'b1;
      end
      default: res_m = res_m;
    endcase
  endtask

  // The answer stands only in the cycle after the strobe edge, so it is sampled there.
  task automatic rd(input logic [4:0] ad);
    logic [15:0] exp;
    exp = exp_rd(ad);
    @(posedge CLK_SYS);
    ADDR <= ad;
    RD_STB <= 1'b1;
    @(posedge CLK_SYS);
    RD_STB <= 1'b0;
    #1;
    chk("rd_valid", {15'h0000, RD_VALID}, 16'h0001);
    chk("rdata", RDATA, exp);
  endtask

  task automatic chk_out();
    chk("pcs_out", {3'b000, BLOCK_CODE_SKIP, RX_CLK_FREE_RUN, TRUE_QUIET_TX_ENABLE,
      SIGNAL_DETECT_FORCE, SIGNAL_DETECT_ALGO_SELECT, 2'b00, FORCE_GOOD_LINK_100, 2'b00,
      NRZI_SKIP, SCRAMBLER_SKIP, DESCRAMBLER_SKIP}, pcs_m);
    chk("misc_out", {4'h0, SELFTEST_LONG_SEQUENCE_SELECT, SELF_TEST_RESULT, SELF_TEST_RUN,
      LED_PULSE_STRETCH_SKIP, 3'b000, PORT_ADDRESS},
      (misc_m & 16'h0B1F) | {5'h00, res_m, 10'h000});
    chk("derived", {13'h0000, SIGNAL_DETECT_PMA, LINK_GOOD_100, DUPLEX_INDICATOR},
      {13'h0000, SIGNAL_DETECT_LINE | pcs_m[9], LINK_GOOD_100_RAW | pcs_m[5],
      DUPLEX_STATUS ^ misc_m[5]});
  endtask

  // Reset with fresh strap levels; the strap-load edge passes before any access.
  task automatic do_reset();
    @(posedge CLK_SYS);
    RST <= 1'b1;
    {STRAP_DUPLEX_LED_POLARITY, STRAP_PORT_ADDRESS} <= 6'($random(seed));
    repeat (2) @(posedge CLK_SYS);
    RST <= 1'b0;
    pcs_m = 16'h0100;
    rsv_a_m = 16'h0000;
    rsv_b_m = 16'h0000;
    res_m = 1'b0;
    misc_m = {10'h000, STRAP_DUPLEX_LED_POLARITY, STRAP_PORT_ADDRESS};
    @(posedge CLK_SYS);
  endtask

  // Reads every mapped address and its unmapped neighbours.
  task automatic rd_all();
    for (int i = 5'h15; i <= 5'h1A; i++)
      rd(5'(i));
    chk_out();
  endtask

  // Watchdog against a hung run.
  initial
  begin
    repeat (20000) @(posedge CLK_SYS);
    err_total++;
    summarize();
  end

  // Main sequence.
  initial
  begin
    {RST, WR_STB, RD_STB, ADDR, WDATA, SELF_TEST_FAIL} = {1'b1, 24'h000000};
    {STRAP_DUPLEX_LED_POLARITY, STRAP_PORT_ADDRESS} = 6'h00;
    {LOCAL_PAUSE_CAPABLE, PARTNER_PAUSE_CAPABLE, SIGNAL_DETECT_LINE} = 3'b000;
    {LINK_GOOD_100_RAW, DUPLEX_STATUS} = 2'b00;
    do_reset();
    rd_all();
    // Self-test: pass on start, latch low on failure, failure beats a same-edge rearm.
    wr(`PPBC_OFS_MISC, misc_m | 16'h0240);
    rd(`PPBC_OFS_MISC);
    @(posedge CLK_SYS);
    SELF_TEST_FAIL <= 1'b1;
    @(posedge CLK_SYS);
    SELF_TEST_FAIL <= 1'b0;
    res_m = 1'b0;
    rd(`PPBC_OFS_MISC);
    @(posedge CLK_SYS);
    SELF_TEST_FAIL <= 1'b1;
    wr(`PPBC_OFS_MISC, misc_m | 16'h0A40);
    SELF_TEST_FAIL <= 1'b0;
    res_m = 1'b0;
    rd(`PPBC_OFS_MISC);
    wr(`PPBC_OFS_MISC, (misc_m & 16'hFDFF) | 16'h0040);
    SELF_TEST_FAIL <= 1'b1;
    @(posedge CLK_SYS);
    SELF_TEST_FAIL <= 1'b0;
    rd(`PPBC_OFS_MISC);
    chk_out();
    // Random traffic; reserved words are only read and reserved bits are kept.
    repeat (80)
    begin
      r = $random(seed);
      d = $random(seed);
      a = r[3] ? r[12:8] : 5'h16 + {2'b00, r[2:0]};
      @(posedge CLK_SYS);
      {LOCAL_PAUSE_CAPABLE, PARTNER_PAUSE_CAPABLE, SIGNAL_DETECT_LINE} <= r[18:16];
      {LINK_GOOD_100_RAW, DUPLEX_STATUS} <= r[20:19];
      if (a != `PPBC_OFS_RSV_A && a != `PPBC_OFS_RSV_B)
        wr(a, (a == `PPBC_OFS_PCS) ? (d & 16'hFFA7) : (d | 16'h0040));
      rd(a);
      chk_out();
    end
    do_reset();
    rd_all();
    summarize();
  end
endmodule
